// ### hdl/cbt_bit_timing.sv
// Bit timing and synchronization logic with its APB register file.
`timescale 1ns/1ns
`include "cbt_cfg.svh"
module cbt_bit_timing (
  input wire logic mclk, // Module clock, 10 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic rx_level, // Bus level, 1 is recessive.
  input wire logic bus_idle, // High while the bus is idle.
  output logic tq_pulse, // One cycle per time quantum.
  output logic sample_pulse, // One cycle at each sample point.
  output logic bit_value, // Value of the last sampled bit.
  output logic [3:0] segment, // Current segment, one-hot.
  output logic hard_sync_pulse, // One cycle after a hard sync.
  output logic resync_pulse // One cycle after a resync.
);
  logic [31:0] cfg_one_ff;
  logic [31:0] cfg_two_ff;
  logic [31:0] prdata_ff;
  logic addr_ok;
  cbt_pkg::cbt_seg_t seg_ff;
  logic [3:0] cnt_ff;
  logic [4:0] pos_ff;
  logic [2:0] ext_ff;
  logic [2:0] shr_ff;
  logic lock_ff;
  logic rx_prev_ff;
  logic hs_ff;
  logic rs_ff;
  logic half_tick;
  logic tq_tick;
  logic fall_edge;
  logic hard_now;
  logic resync_now;
  logic sample_now;
  logic [3:0] prop_len;
  logic [3:0] ph1_len;
  logic [3:0] ph2_len;
  logic [3:0] ph2_field_len;
  logic [2:0] jump_len;
  logic [4:0] bit_len;
  logic cfg_err;
  logic [3:0] rem_len;
  logic [2:0] nxt_ext;
  logic [2:0] nxt_shr;

  // APB slave: zero wait states, error on unmapped addresses.
  assign addr_ok = (paddr == `CBT_OFF_CFG_ONE) || (paddr == `CBT_OFF_CFG_TWO) ||
                   (paddr == `CBT_OFF_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_ff;

  // Configuration registers written in the access phase.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_one_ff <= `CBT_RST_CFG_ONE;
      cfg_two_ff <= `CBT_RST_CFG_TWO;
    end else if (psel && penable && pwrite) begin
      if (paddr == `CBT_OFF_CFG_ONE) begin
        cfg_one_ff <= {24'h000000, pwdata[7:0]};
      end
      if (paddr == `CBT_OFF_CFG_TWO) begin
        cfg_two_ff <= {21'h000000, pwdata[10:0]};
      end
    end
  end

  // Read data is captured in the setup phase so it stands in the access phase.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `CBT_OFF_CFG_ONE: prdata_ff <= cfg_one_ff;
        `CBT_OFF_CFG_TWO: prdata_ff <= cfg_two_ff;
        `CBT_OFF_STATUS: prdata_ff <= {21'h000000, pos_ff, seg_ff, cfg_err, bit_value};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Segment lengths decode as field plus one quantum; phase two without its program bit takes the longer of phase one and two quanta.
  assign prop_len = {1'b0, cfg_two_ff[`CBT_PROP_HI:`CBT_PROP_LO]} + 4'h1;
  assign ph1_len = {1'b0, cfg_two_ff[`CBT_PH1_HI:`CBT_PH1_LO]} + 4'h1;
  assign ph2_field_len = {1'b0, cfg_two_ff[`CBT_PH2_HI:`CBT_PH2_LO]} + 4'h1;
  assign ph2_len = cfg_two_ff[`CBT_PH2_PROG_BIT] ? ph2_field_len :
                   ((ph1_len > `CBT_PROC_TQ) ? ph1_len : `CBT_PROC_TQ);
  assign jump_len = {1'b0, cfg_one_ff[`CBT_JUMP_HI:`CBT_JUMP_LO]} + 3'h1;

  // Nominal length check; one sync quantum plus the three programmed segments.
  assign bit_len = 5'h01 + {1'b0, prop_len} + {1'b0, ph1_len} + {1'b0, ph2_len};
  assign cfg_err = (bit_len < `CBT_BIT_MIN_TQ) || (bit_len > `CBT_BIT_MAX_TQ);

  cbt_quantum_prescaler u_presc (
    .mclk(mclk),
    .rstn(rstn),
    .restart(hard_now),
    .prescale(cfg_one_ff[`CBT_PRESC_HI:`CBT_PRESC_LO]),
    .half_tick_ff(half_tick),
    .tq_tick_ff(tq_tick)
  );

  // Edge detection on the bus: recessive to dominant.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= rx_level;
    end
  end

  assign fall_edge = rx_prev_ff && !rx_level;
  assign hard_now = fall_edge && bus_idle;
  assign resync_now = fall_edge && !bus_idle && !lock_ff && (seg_ff != cbt_pkg::CBT_SYNC);
  assign sample_now = tq_tick && !hard_now && (seg_ff == cbt_pkg::CBT_PH1) &&
                      (cnt_ff == ph1_len + {1'b0, ext_ff} - 4'h1);

  // Phase error bounded by the jump width; late edge lengthens, early one shortens.
  assign rem_len = ph2_len - cnt_ff;
  assign nxt_ext = (pos_ff > {2'b00, jump_len}) ? jump_len : pos_ff[2:0];
  assign nxt_shr = (rem_len > {1'b0, jump_len}) ? jump_len : rem_len[2:0];

  // Segment sequencer advanced on each quantum.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      seg_ff <= cbt_pkg::CBT_SYNC;
      cnt_ff <= 4'h0;
    end else if (hard_now) begin
      seg_ff <= cbt_pkg::CBT_SYNC;
      cnt_ff <= 4'h0;
    end else if (tq_tick) begin
      unique case (seg_ff)
        cbt_pkg::CBT_SYNC: begin
          seg_ff <= cbt_pkg::CBT_PROP;
          cnt_ff <= 4'h0;
        end
        cbt_pkg::CBT_PROP: begin
          if (cnt_ff == prop_len - 4'h1) begin
            seg_ff <= cbt_pkg::CBT_PH1;
            cnt_ff <= 4'h0;
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        cbt_pkg::CBT_PH1: begin
          if (sample_now) begin
            seg_ff <= cbt_pkg::CBT_PH2;
            cnt_ff <= 4'h0;
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        cbt_pkg::CBT_PH2: begin
          if (cnt_ff + 4'h1 >= ph2_len - {1'b0, shr_ff}) begin
            seg_ff <= cbt_pkg::CBT_SYNC;
            cnt_ff <= 4'h0;
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
      endcase
    end
  end

  // Quanta elapsed since the start of the bit.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pos_ff <= 5'h00;
    end else if (hard_now) begin
      pos_ff <= 5'h00;
    end else if (tq_tick) begin
      if (seg_ff == cbt_pkg::CBT_PH2 && (cnt_ff + 4'h1 >= ph2_len - {1'b0, shr_ff})) begin
        pos_ff <= 5'h00;
      end else begin
        pos_ff <= pos_ff + 5'h01;
      end
    end
  end

  // Phase adjustments and the once-per-bit lock, cleared at the end of each phase two; a hard sync sets the lock.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ext_ff <= 3'h0;
      shr_ff <= 3'h0;
      lock_ff <= 1'b0;
    end else if (hard_now) begin
      ext_ff <= 3'h0;
      shr_ff <= 3'h0;
      lock_ff <= 1'b1;
    end else if (resync_now) begin
      lock_ff <= 1'b1;
      if (seg_ff == cbt_pkg::CBT_PH2) begin
        shr_ff <= nxt_shr;
      end else begin
        ext_ff <= nxt_ext;
      end
    end else if (tq_tick && seg_ff == cbt_pkg::CBT_PH2 &&
                 (cnt_ff + 4'h1 >= ph2_len - {1'b0, shr_ff})) begin
      ext_ff <= 3'h0;
      shr_ff <= 3'h0;
      lock_ff <= 1'b0;
    end
  end

  cbt_majority_sampler u_sampler (
    .mclk(mclk),
    .rstn(rstn),
    .half_tick(half_tick),
    .rx_level(rx_level),
    .sample_now(sample_now),
    .triple(cfg_two_ff[`CBT_TRIPLE_BIT]),
    .bit_ff(bit_value)
  );

  // Registered event pulses.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hs_ff <= 1'b0;
      rs_ff <= 1'b0;
    end else begin
      hs_ff <= hard_now;
      rs_ff <= resync_now;
    end
  end

  assign hard_sync_pulse = hs_ff;
  assign resync_pulse = rs_ff;
  assign tq_pulse = tq_tick;
  assign sample_pulse = sample_now;
  assign segment = seg_ff;

  // Clocks since the last quantum tick, for the quantum period check.
  // A prescale write makes the quantum in flight irregular, so that period is not judged.
  logic [7:0] gap_ff;
  logic seen_ff;
  logic cfg_one_wr;
  assign cfg_one_wr = psel && penable && pwrite && (paddr == `CBT_OFF_CFG_ONE);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gap_ff <= 8'h00;
    end else if (hard_now || tq_tick) begin
      gap_ff <= 8'h00;
    end else begin
      gap_ff <= gap_ff + 8'h01;
    end
  end

  // Marks that the last quantum tick started a period under a settled prescale value.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      seen_ff <= 1'b0;
    end else if (cfg_one_wr) begin
      seen_ff <= 1'b0;
    end else if (hard_now || tq_tick) begin
      seen_ff <= tq_tick && !hard_now;
    end
  end

  property p_quantum_period;
    @(posedge mclk) disable iff (!rstn)
    (tq_tick && seen_ff && $stable(cfg_one_ff)) |->
      (gap_ff == {1'b0, cfg_one_ff[5:0], 1'b1});
  endproperty
  a_quantum_period: assert property (p_quantum_period) else $error("quantum period wrong");

  property p_sync_one_tq;
    @(posedge mclk) disable iff (!rstn)
    (seg_ff == cbt_pkg::CBT_SYNC && tq_tick && !hard_now) |=> (seg_ff == cbt_pkg::CBT_PROP);
  endproperty
  a_sync_one_tq: assert property (p_sync_one_tq) else $error("sync segment not one quantum");

  property p_prop_len;
    @(posedge mclk) disable iff (!rstn)
    (seg_ff == cbt_pkg::CBT_PROP && tq_tick && !hard_now && cnt_ff == prop_len - 4'h1)
      |=> (seg_ff == cbt_pkg::CBT_PH1 && cnt_ff == 4'h0);
  endproperty
  a_prop_len: assert property (p_prop_len) else $error("propagation segment length wrong");

  property p_sample_end_ph1;
    @(posedge mclk) disable iff (!rstn)
    sample_pulse |=> (seg_ff == cbt_pkg::CBT_PH2 && cnt_ff == 4'h0);
  endproperty
  a_sample_end_ph1: assert property (p_sample_end_ph1) else $error("sample not at end of phase one");

  property p_single_sample;
    @(posedge mclk) disable iff (!rstn)
    (sample_now && !cfg_two_ff[6]) |=> (bit_value == $past(rx_level));
  endproperty
  a_single_sample: assert property (p_single_sample) else $error("single sample value wrong");

  property p_hard_sync;
    @(posedge mclk) disable iff (!rstn)
    (rx_prev_ff && !rx_level && bus_idle) |=>
      (seg_ff == cbt_pkg::CBT_SYNC && pos_ff == 5'h00 && hard_sync_pulse);
  endproperty
  a_hard_sync: assert property (p_hard_sync) else $error("hard sync did not restart bit");

  property p_jump_bound;
    @(posedge mclk) disable iff (!rstn)
    resync_pulse |-> (ext_ff <= jump_len && shr_ff <= jump_len);
  endproperty
  a_jump_bound: assert property (p_jump_bound) else $error("phase change exceeds jump width");

  property p_no_resync_after_hard;
    @(posedge mclk) disable iff (!rstn)
    hard_sync_pulse |->
      ((lock_ff && !resync_now) throughout (##[0:200] (tq_tick && seg_ff == cbt_pkg::CBT_SYNC)));
  endproperty
  a_no_resync_after_hard: assert property (p_no_resync_after_hard) else $error("resync after hard sync");

  c_hard_sync: cover property (@(posedge mclk) disable iff (!rstn) hard_sync_pulse);
  c_lengthen: cover property (@(posedge mclk) disable iff (!rstn) resync_pulse && ext_ff != 3'h0);
  c_shorten: cover property (@(posedge mclk) disable iff (!rstn) resync_pulse && shr_ff != 3'h0);
  c_triple: cover property (@(posedge mclk) disable iff (!rstn) sample_now && cfg_two_ff[6]);
endmodule : cbt_bit_timing

// ### hdl/cbt_majority_sampler.sv
// Bus level sampler with optional three-sample majority vote.
`timescale 1ns/1ns
module cbt_majority_sampler (
  input wire logic mclk, // Module clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic half_tick, // Half quantum pulse.
  input wire logic rx_level, // Bus level, 1 is recessive.
  input wire logic sample_now, // Sample point pulse.
  input wire logic triple, // Selects majority of three samples.
  output logic bit_ff // Value of the current bit.
);
  logic [1:0] hist_ff;
  logic vote;

  // Keeps the bus level of the two last half quantum points.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hist_ff <= 2'h3;
    end else if (half_tick) begin
      hist_ff <= {hist_ff[0], rx_level};
    end
  end

  // Majority of the level now and two earlier points half a quantum apart.
  assign vote = (hist_ff[1] & hist_ff[0]) | (hist_ff[1] & rx_level) | (hist_ff[0] & rx_level);

  // Bit value taken at the sample point.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bit_ff <= 1'b1;
    end else if (sample_now) begin
      bit_ff <= triple ? vote : rx_level;
    end
  end
endmodule : cbt_majority_sampler

// ### hdl/cbt_quantum_prescaler.sv
// Quantum clock generator: prescaler with a fixed divide-by-two stage.
`timescale 1ns/1ns
module cbt_quantum_prescaler (
  input wire logic mclk, // Module clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic restart, // Restarts the quantum at this cycle.
  input wire logic [5:0] prescale, // Prescaler field value.
  output logic half_tick_ff, // Pulse every half quantum.
  output logic tq_tick_ff // Pulse every quantum.
);
  logic [5:0] cnt_ff;
  logic phase_ff;
  logic wrap;

  // Each half quantum lasts prescale plus one clocks; two halves make one quantum.
  assign wrap = (cnt_ff == prescale);

  // Counts clocks within a half quantum.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 6'h00;
    end else if (restart || wrap) begin
      cnt_ff <= 6'h00;
    end else begin
      cnt_ff <= cnt_ff + 6'h01;
    end
  end

  // Fixed divide-by-two stage behind the prescaler.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase_ff <= 1'b0;
    end else if (restart) begin
      phase_ff <= 1'b0;
    end else if (wrap) begin
      phase_ff <= ~phase_ff;
    end
  end

  // Registered tick pulses.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      half_tick_ff <= 1'b0;
      tq_tick_ff <= 1'b0;
    end else begin
      half_tick_ff <= wrap && !restart;
      tq_tick_ff <= wrap && !restart && phase_ff;
    end
  end
endmodule : cbt_quantum_prescaler

// ### shared/cbt_cfg.svh
// Offsets, field positions, reset values and timing figures of the bit timing block.
`ifndef CBT_CFG_SVH
`define CBT_CFG_SVH
`define CBT_OFF_CFG_ONE 8'h00
`define CBT_OFF_CFG_TWO 8'h04
`define CBT_OFF_STATUS 8'h08
`define CBT_RST_CFG_ONE 32'h0000_0000
`define CBT_RST_CFG_TWO 32'h0000_0000
`define CBT_PRESC_HI 5
`define CBT_PRESC_LO 0
`define CBT_JUMP_HI 7
`define CBT_JUMP_LO 6
`define CBT_PROP_HI 2
`define CBT_PROP_LO 0
`define CBT_PH1_HI 5
`define CBT_PH1_LO 3
`define CBT_TRIPLE_BIT 6
`define CBT_PH2_PROG_BIT 7
`define CBT_PH2_HI 10
`define CBT_PH2_LO 8
`define CBT_PROC_TQ 4'h2
`define CBT_BIT_MIN_TQ 5'h08
`define CBT_BIT_MAX_TQ 5'h19
`endif

// ### shared/cbt_pkg.sv
// Types shared by the bit timing block.
package cbt_pkg;
  typedef enum logic [3:0] {
    CBT_SYNC = 4'h1,
    CBT_PROP = 4'h2,
    CBT_PH1 = 4'h4,
    CBT_PH2 = 4'h8
  } cbt_seg_t;
endpackage : cbt_pkg

// ### verification/cbt_bit_timing_tb.sv
// Self-checking testbench of the bit timing block.
`timescale 1ns/1ns
`include "cbt_cfg.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin num_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module cbt_bit_timing_tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, rx_level, bus_idle, tq_pulse, sample_pulse, bit_value;
  logic hard_sync_pulse, resync_pulse;
  logic [3:0] segment;
  logic start = 1'b0;
  logic [15:0] a0 = 16'h0000, a1 = 16'h0000, b0 = 16'h0000, b1 = 16'h0000, flen = 16'h0010;
  logic [31:0] rng = 32'h0000_5344;
  logic [32:0] rq[$];
  logic [7:0] sq[$];
  logic bq[$];
  logic [32:0] rd_e;
  logic [7:0] seg_e;
  logic [3:0] seg_q = 4'h1;
  logic sample_q = 1'b0;
  int tq_cnt = 0;
  int n_rs = 0;
  int num_errors = 0;
  int n_checks = 0;

  cbt_bit_timing u_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_level(rx_level), .bus_idle(bus_idle), .tq_pulse(tq_pulse),
    .sample_pulse(sample_pulse), .bit_value(bit_value), .segment(segment),
    .hard_sync_pulse(hard_sync_pulse), .resync_pulse(resync_pulse));
  cbt_bus_node u_node (.mclk(mclk), .rstn(rstn), .start(start), .a0(a0), .a1(a1), .b0(b0),
    .b1(b1), .flen(flen), .rx_level(rx_level), .bus_idle(bus_idle));

  // Clock of 100 ns period.
  always #50 mclk = ~mclk;

  // Xorshift source for register data and prescale values.
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd

  // Read data and error flag are compared at the completing access edge.
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
      rd_e = rq.pop_front();
      `CHK("apb read", rd_e, {pslverr, prdata})
    end
  end

  // Each segment run is checked for its code and its length in quanta.
  always @(posedge mclk) begin
    if (resync_pulse === 1'b1) n_rs++;
    if (hard_sync_pulse === 1'b1) tq_cnt = 0;
    else if (segment !== seg_q) begin
      if (sq.size() > 0) begin
        seg_e = sq.pop_front();
        `CHK("segment run", seg_e, {seg_q, 4'(tq_cnt)})
      end
      tq_cnt = (tq_pulse === 1'b1) ? 1 : 0;
    end else if (tq_pulse === 1'b1) tq_cnt++;
    seg_q = segment;
    if (sample_q && bq.size() > 0) `CHK("bit value", bq.pop_front(), bit_value)
    sample_q = (sample_pulse === 1'b1);
  end

  // One APB transfer; a read notes its expected error flag and data first.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] ex);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) rq.push_back(ex);
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  // Configures, lets the partner open a frame and notes two bits of expectations.
  task automatic run_frame(input logic [5:0] p, input logic [1:0] sj, input logic [10:0] c2,
                           input logic gl, input logic rs);
    int tq, pr, ph1, ph2, len, sp, ext;
    tq = 2 * (int'(p) + 1);
    pr = int'(c2[2:0]) + 1;
    ph1 = int'(c2[5:3]) + 1;
    ph2 = c2[7] ? int'(c2[10:8]) + 1 : (ph1 > 2 ? ph1 : 2);
    len = 1 + pr + ph1 + ph2;
    sp = (1 + pr + ph1) * tq;
    ext = rs ? (int'(sj) + 1 < 2 ? int'(sj) + 1 : 2) : 0;
    n_rs = 0;
    apb(1'b1, `CBT_OFF_CFG_ONE, {24'h0, sj, p}, 33'h0);
    apb(1'b1, `CBT_OFF_CFG_TWO, {21'h0, c2}, 33'h0);
    a0 <= 16'(gl ? sp - 2 : tq);
    a1 <= 16'(gl ? sp + 3 : tq + tq / 2);
    b0 <= 16'(rs ? (len + 1) * tq : 0);
    b1 <= 16'(rs ? (len + 2) * tq + tq / 2 : 0);
    flen <= 16'(3 * len * tq + 20);
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    do @(posedge mclk); while (hard_sync_pulse !== 1'b1);
    for (int b = 0; b < 2; b++) begin
      sq.push_back({4'h1, 4'h1});
      sq.push_back({4'h2, 4'(pr)});
      sq.push_back({4'h4, 4'(ph1 + (b == 1 ? ext : 0))});
      sq.push_back({4'h8, 4'(ph2)});
    end
    @(posedge mclk);
    bq.push_back(gl ? !c2[`CBT_TRIPLE_BIT] : 1'b0);
    bq.push_back(1'b0);
    while (sq.size() > 0 || bq.size() > 0 || bus_idle !== 1'b1) @(posedge mclk);
    `CHK("resync count", int'(rs), n_rs)
  endtask : run_frame

  // Prints the verdict and ends the run.
  task automatic test_done();
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // Cuts a hang short.
  initial begin
    repeat (30000) @(posedge mclk);
    num_errors++;
    test_done();
  end

  // Main sequence: reset, registers, quantum periods, then frames.
  initial begin
    logic [31:0] r;
    logic [5:0] pv[4];
    int t;
    repeat (12) @(posedge mclk);
    `CHK("reset segment", 4'h1, segment)
    `CHK("reset bit", 1'b1, bit_value)
    rstn <= 1'b1;
    @(posedge mclk);
    r = rnd();
    apb(1'b0, `CBT_OFF_CFG_ONE, 32'h0, {1'b0, `CBT_RST_CFG_ONE});
    apb(1'b0, `CBT_OFF_CFG_TWO, 32'h0, {1'b0, `CBT_RST_CFG_TWO});
    apb(1'b1, `CBT_OFF_CFG_ONE, r, 33'h0);
    apb(1'b1, `CBT_OFF_CFG_TWO, ~r, 33'h0);
    apb(1'b1, 8'h0c, 32'h0000_0000, 33'h0);
    apb(1'b0, 8'h0c, 32'h0, 33'h1_0000_0000);
    apb(1'b0, `CBT_OFF_CFG_ONE, 32'h0, {25'h0, r[7:0]});
    apb(1'b0, `CBT_OFF_CFG_TWO, 32'h0, {22'h0, ~r[10:0]});
    pv = '{6'h00, 6'h01, 6'h3f, r[13:8]};
    foreach (pv[i]) begin
      apb(1'b1, `CBT_OFF_CFG_ONE, {26'h0, pv[i]}, 33'h0);
      repeat (2) do @(posedge mclk); while (tq_pulse !== 1'b1);
      t = 0;
      do begin
        @(posedge mclk);
        t++;
      end while (tq_pulse !== 1'b1);
      `CHK("quantum clocks", 2 * (int'(pv[i]) + 1), t)
    end
    // Bit times of 13, 13, 12 and 8 quanta, each at least 1 us.
    run_frame(6'h01, 2'h3, 11'h49a, 1'b0, 1'b1);
    run_frame(6'h01, 2'h0, 11'h49a, 1'b0, 1'b1);
    run_frame(6'h05, 2'h0, 11'h05a, 1'b1, 1'b0);
    run_frame(6'h05, 2'h0, 11'h003, 1'b1, 1'b0);
    test_done();
  end
endmodule : cbt_bit_timing_tb

// ### verification/cbt_bus_node.sv
// Model of another node on the bus that opens a frame with two recessive windows.
`timescale 1ns/1ns
module cbt_bus_node (
  input wire logic mclk, // Module clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic start, // Opens a frame.
  input wire logic [15:0] a0, // First recessive window start, in clocks.
  input wire logic [15:0] a1, // First recessive window end.
  input wire logic [15:0] b0, // Second recessive window start.
  input wire logic [15:0] b1, // Second recessive window end.
  input wire logic [15:0] flen, // Frame length in clocks.
  output logic rx_level, // Bus level, 1 is recessive.
  output logic bus_idle // High while no frame is on the bus.
);
  logic busy_ff;
  logic rx_ff;
  logic idle_ff;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  assign nxt_cnt = cnt_ff + 16'h0001;
  assign rx_level = rx_ff;
  assign bus_idle = idle_ff;
  // A frame opens dominant, goes recessive inside the windows and at its end.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy_ff <= 1'b0;
      cnt_ff <= 16'h0000;
      rx_ff <= 1'b1;
    end else if (start && !busy_ff) begin
      busy_ff <= 1'b1;
      cnt_ff <= 16'h0000;
      rx_ff <= 1'b0;
    end else if (busy_ff) begin
      cnt_ff <= nxt_cnt;
      busy_ff <= (nxt_cnt != flen);
      rx_ff <= (nxt_cnt >= flen) || (nxt_cnt >= a0 && nxt_cnt < a1) ||
               (nxt_cnt >= b0 && nxt_cnt < b1);
    end
  end
  // Idle drops one clock after the opening edge, so that edge meets an idle bus.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) idle_ff <= 1'b1;
    else idle_ff <= !busy_ff;
  end
endmodule : cbt_bus_node
